// File: common/sar_map.svh
// register offsets, field positions and reset values of the approximation register
`ifndef SAR_MAP_SVH
`define SAR_MAP_SVH

`define SAR_ADDR_W       8
`define SAR_DATA_W       32
`define SAR_RES_W        8

`define SAR_OFS_CTRL     8'h00
`define SAR_OFS_STATUS   8'h04
`define SAR_OFS_MASK     8'h08
`define SAR_OFS_RESULT   8'h0C

`define SAR_CTRL_FF_BIT  0
`define SAR_EVT_DONE     0
`define SAR_EVT_START    1
`define SAR_EVT_W        2
`define SAR_RES_DONE_BIT 8
`define SAR_RES_BUSY_BIT 9

`define SAR_CTRL_RST     1'h0
`define SAR_MASK_RST     2'h0
`define SAR_RESULT_RST   8'h00
`define SAR_MSB_TRIAL    8'h80
`define SAR_LSB_INDEX    3'h0
`define SAR_MSB_INDEX    3'h7

`endif

// File: common/sar_pkg.sv
// types shared by the approximation register design
package sar_pkg;
	typedef enum logic [1:0] {
		SAR_CLEARED,
		SAR_BUSY,
		SAR_DONE
	} sar_state_t;
endpackage

// File: rtl/sar_core.sv
// 8-bit successive approximation register with control port and interrupt
// Function
// R01: holds an 8-bit result and sequences the whole conversion by itself.
// R02: every control input is sampled only on the rising clock edge.
// R03: cascades beyond 8 bits use the clear variant to hold the downstream part.
// R04: feed-forward variant ends conversion early when shorten input is high.
// R05: start request rising with clear low begins a new conversion.
// R06: start request held high with clear low continues the ongoing conversion.
// R07: start request low and clear low carries on the previous operation.
// R08: feed-forward variant keeps result while done and start low; restarts on start.
// R09: supports free-running (start held) and strobed (start pulsed) operation.
// R10: no stable lock-up state while done is low under continuous clocking.
// R11: clear variant needs start high for that; feed-forward variant needs nothing.
// R12: feed-forward variant recirculates after done when start is held high.
// R13: result appears as parallel bits and as a serial bit stream.
// R14: clear zeroes all outputs next edge; stays cleared until start goes high (here outputs zero on the fifth edge that samples clear, after the pin filter).
// R15: trial bits set MSB first, then kept or cleared by the comparator.
// R16: done rises after the LSB decision or after the shorten input.
// R17: serial bit shown while decided; inhibited first period, cleared, after done.
// R18: comparator decision is settled before the edge that samples it.
//
// Decided for this implementation: the plain strobed port and the register offsets.
`include "sar_map.svh"
`timescale 1ns/1ps
`default_nettype none

module sar_core (
	// clock and reset
	input  wire logic                    ref_clk,
	input  wire logic                    reset,
	// converter pins
	input  wire logic                    begin_request,
	input  wire logic                    sync_clear,
	input  wire logic                    shorten_input,
	input  wire logic                    comp_in,
	output logic      [`SAR_RES_W-1:0]   result_bits,
	output logic                         serial_out,
	output logic                         conv_done,
	// register port
	input  wire logic [`SAR_ADDR_W-1:0]  reg_addr,
	input  wire logic [`SAR_DATA_W-1:0]  reg_wdata,
	input  wire logic                    reg_wr,
	input  wire logic                    reg_rd,
	output logic      [`SAR_DATA_W-1:0]  reg_rdata,
	// interrupt
	output logic                         irq
);

	// three-stage pin filter: value moves once stages two and three agree
	function automatic logic filt(input logic s2, input logic s3, input logic cur);
		filt = (s2 == s3) ? s3 : cur;
	endfunction

	logic [2:0]               beg_s;
	logic [2:0]               clr_s;
	logic [2:0]               sht_s;
	logic                     beg_f;
	logic                     clr_f;
	logic                     sht_f;
	logic                     cmp_f;
	logic                     beg_prev;
	logic                     clr_prev;
	logic                     ff_mode;
	logic [`SAR_EVT_W-1:0]    status;
	logic [`SAR_EVT_W-1:0]    mask;
	logic [`SAR_EVT_W-1:0]    evt;
	sar_pkg::sar_state_t      state;
	logic [2:0]               bit_idx;
	logic                     clr_evt;
	logic                     start_evt;
	logic                     stop_evt;
	logic                     last_bit;
	logic [`SAR_RES_W-1:0]    decided;
	logic                     done_d;

	// input synchronisers, all sampled on the rising edge
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			beg_s <= 3'h0;
			clr_s <= 3'h0;
			sht_s <= 3'h0;
		end else begin
			beg_s <= {beg_s[1:0], begin_request}; // [R02]
			clr_s <= {clr_s[1:0], sync_clear};
			sht_s <= {sht_s[1:0], shorten_input};
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			beg_f    <= 1'b0;
			clr_f    <= 1'b0;
			sht_f    <= 1'b0;
			beg_prev <= 1'b0;
			clr_prev <= 1'b0;
		end else begin
			beg_f    <= filt(beg_s[1], beg_s[2], beg_f); // [R02]
			clr_f    <= filt(clr_s[1], clr_s[2], clr_f);
			sht_f    <= filt(sht_s[1], sht_s[2], sht_f);
			beg_prev <= beg_f;
			clr_prev <= clr_f;
		end
	end

	// comparator sits behind our own registered trial bits, so it is already on
	// this clock; filtering it would decide each bit from a stale trial
	assign cmp_f = comp_in; // [R18] [R15]

	// clear only exists in the clear variant
	assign clr_evt = !ff_mode && clr_f; // [R14] [R03]

	// start conditions of both variants
	always_comb begin
		start_evt = 1'b0;
		if (!clr_evt) begin
			if (beg_f && !beg_prev)
				start_evt = 1'b1; // [R05] [R09]
			else if (beg_f && !ff_mode && clr_prev)
				start_evt = 1'b1; // [R14]
			else if (beg_f && ff_mode && state == sar_pkg::SAR_DONE)
				start_evt = 1'b1; // [R08] [R12]
			else if (ff_mode && state == sar_pkg::SAR_CLEARED)
				start_evt = 1'b1; // [R10] [R11]
		end
	end

	assign last_bit = (bit_idx == `SAR_LSB_INDEX);
	assign stop_evt = state == sar_pkg::SAR_BUSY && !clr_evt && !start_evt
		&& (last_bit || (ff_mode && sht_f)); // [R04] [R16]

	// keep or drop the current trial bit, then raise the next one
	always_comb begin
		decided = result_bits;
		decided[bit_idx] = cmp_f; // [R15]
		if (!last_bit)
			decided[bit_idx - 3'h1] = 1'b1;
	end

	// conversion sequencer
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			state       <= sar_pkg::SAR_CLEARED;
			bit_idx     <= `SAR_MSB_INDEX;
			result_bits <= `SAR_RESULT_RST;
			conv_done   <= 1'b0;
		end else if (clr_evt) begin
			state       <= sar_pkg::SAR_CLEARED; // [R14]
			bit_idx     <= `SAR_MSB_INDEX;
			result_bits <= `SAR_RESULT_RST;
			conv_done   <= 1'b0;
		end else if (start_evt) begin
			state       <= sar_pkg::SAR_BUSY; // [R05] [R01]
			bit_idx     <= `SAR_MSB_INDEX;
			result_bits <= `SAR_MSB_TRIAL; // [R15]
			conv_done   <= 1'b0;
		end else begin
			case (state)
				sar_pkg::SAR_BUSY: begin
					result_bits <= decided; // [R06] [R07]
					if (stop_evt) begin
						state     <= sar_pkg::SAR_DONE;
						conv_done <= 1'b1; // [R16] [R04]
					end else begin
						bit_idx <= bit_idx - 3'h1;
					end
				end
				sar_pkg::SAR_DONE: begin
					conv_done <= 1'b1; // [R08] [R07]
				end
				sar_pkg::SAR_CLEARED: begin
					conv_done <= 1'b0; // [R07]
				end
				default: begin
					state <= sar_pkg::SAR_CLEARED;
				end
			endcase
		end
	end

	// serial stream: the bit just decided, zero otherwise
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			serial_out <= 1'b0;
		end else if (!clr_evt && !start_evt && state == sar_pkg::SAR_BUSY) begin
			serial_out <= cmp_f; // [R13] [R17]
		end else begin
			serial_out <= 1'b0; // [R17]
		end
	end

	// interrupt events: done rising and conversion start
	always_ff @(posedge ref_clk) begin
		if (reset)
			done_d <= 1'b0;
		else
			done_d <= conv_done;
	end

	assign evt[`SAR_EVT_DONE]  = conv_done && !done_d;
	assign evt[`SAR_EVT_START] = start_evt;

	// control and mask registers
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			ff_mode <= `SAR_CTRL_RST;
			mask    <= `SAR_MASK_RST;
		end else if (reg_wr) begin
			if (reg_addr == `SAR_OFS_CTRL)
				ff_mode <= reg_wdata[`SAR_CTRL_FF_BIT];
			if (reg_addr == `SAR_OFS_MASK)
				mask <= reg_wdata[`SAR_EVT_W-1:0];
		end
	end

	// sticky status, write one to clear, a new event wins
	always_ff @(posedge ref_clk) begin
		if (reset)
			status <= '0;
		else if (reg_wr && reg_addr == `SAR_OFS_STATUS)
			status <= (status & ~reg_wdata[`SAR_EVT_W-1:0]) | evt;
		else
			status <= status | evt;
	end

	assign irq = |(status & mask);

	// read data, one cycle after the strobe; unmapped reads give zero
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			reg_rdata <= '0;
		end else if (reg_rd) begin
			case (reg_addr)
				`SAR_OFS_CTRL:   reg_rdata <= {31'h0, ff_mode};
				`SAR_OFS_STATUS: reg_rdata <= {30'h0, status};
				`SAR_OFS_MASK:   reg_rdata <= {30'h0, mask};
				`SAR_OFS_RESULT: reg_rdata <= {22'h0, state == sar_pkg::SAR_BUSY,
					conv_done, result_bits};
				default:         reg_rdata <= '0;
			endcase
		end else begin
			reg_rdata <= '0;
		end
	end

	// checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	sequence s_start;
		start_evt;
	endsequence

	sequence s_trial_msb;
		result_bits == `SAR_MSB_TRIAL && !conv_done && state == sar_pkg::SAR_BUSY;
	endsequence

	a_clear_zero: assert property (clr_evt |=> result_bits == 8'h00 && !conv_done // [R14]
		&& !serial_out)
		else $error("clear did not zero outputs");

	a_start_msb: assert property (s_start |=> s_trial_msb) // [R05]
		else $error("start did not raise the msb trial");

	a_continue_run: assert property (state == sar_pkg::SAR_BUSY && !start_evt // [R06]
		&& !clr_evt && !stop_evt |=> state == sar_pkg::SAR_BUSY && bit_idx == $past(bit_idx) - 3'h1)
		else $error("conversion did not advance");

	a_lsb_done: assert property (state == sar_pkg::SAR_BUSY && last_bit && !clr_evt // [R16]
		&& !start_evt |=> conv_done && result_bits[0] == $past(cmp_f))
		else $error("done missing after lsb decision");

	a_shorten_done: assert property (ff_mode && state == sar_pkg::SAR_BUSY && sht_f // [R04]
		&& !start_evt |=> conv_done)
		else $error("shorten input did not end conversion");

	a_retain_result: assert property (conv_done && !start_evt && !clr_evt // [R08]
		|=> $stable(result_bits) && conv_done)
		else $error("result not retained");

	a_ff_recirc: assert property (ff_mode && conv_done && beg_f |=> s_trial_msb) // [R12]
		else $error("no recirculation after done");

	a_no_lockup: assert property (ff_mode && state == sar_pkg::SAR_CLEARED // [R10] [R11]
		|=> state == sar_pkg::SAR_BUSY)
		else $error("feed-forward variant sat in cleared state");

	a_full_length: assert property (s_start ##1 (!clr_evt && !start_evt && !ff_mode)[*8] // [R01]
		|=> conv_done && !$past(conv_done))
		else $error("8-bit conversion length wrong");

	a_serial_inh: assert property (s_start |=> !serial_out) // [R17]
		else $error("serial output not inhibited in first period");

	a_serial_bit: assert property (state == sar_pkg::SAR_BUSY && !start_evt && !clr_evt // [R13] [R17]
		|=> serial_out == $past(cmp_f))
		else $error("serial output does not carry the decided bit");

	a_pin_filter: assert property ($changed(beg_f) |-> $past(beg_s[1]) == $past(beg_s[2])) // [R02]
		else $error("start request changed without agreement");

	a_done_irq: assert property ($rose(conv_done) |=> status[`SAR_EVT_DONE]) // [R16]
		else $error("done event not latched");

endmodule // sar_core

`default_nettype wire

// File: sim/sar_adc_model.sv
// comparator and converter model facing the approximation register
`timescale 1ns/1ps
`default_nettype none

module sar_adc_model (
	// converter side
	input  wire logic [7:0] result_bits,
	input  wire logic [7:0] target,
	// comparator decision
	output logic            comp_in
);
	// ideal converter: keep the trial bit while its level does not exceed the input
	assign comp_in = (result_bits <= target);
endmodule // sar_adc_model

`default_nettype wire

// File: sim/sar_core_test.sv
// self-checking bench for the approximation register
`include "sar_map.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin num_errors++; $display("FAIL t=%0t got=%h exp=%h", $time, (g), (e)); end end

module sar_core_test;
	logic        ref_clk, reset, begin_request, sync_clear, shorten_input, comp_in;
	logic        serial_out, conv_done, irq, reg_wr, reg_rd, sh_en;
	logic [7:0]  result_bits, target, reg_addr;
	logic [31:0] reg_wdata, reg_rdata, rv;
	int          num_errors, checked, n;

	sar_core sar_core_inst (.ref_clk(ref_clk), .reset(reset), .begin_request(begin_request),
		.sync_clear(sync_clear), .shorten_input(shorten_input), .comp_in(comp_in),
		.result_bits(result_bits), .serial_out(serial_out), .conv_done(conv_done),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .irq(irq));
	sar_adc_model sar_adc_model_inst (.result_bits(result_bits), .target(target), .comp_in(comp_in));

	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	// shortening tied to the msb, as a system would strap it
	always @(posedge ref_clk) begin
		shorten_input <= sh_en & result_bits[7];
	end

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(negedge ref_clk);
		rv = reg_rdata;
	endtask

	task automatic cyc(input int k);
		repeat (k) @(posedge ref_clk);
	endtask

	task automatic wait_done(input logic lvl);
		n = 0;
		@(negedge ref_clk);
		while (conv_done !== lvl && n < 40) begin
			@(negedge ref_clk);
			n++;
		end
		`CHK(conv_done, lvl)
	endtask

	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	initial begin
		#20000;
		num_errors++;
		tally_and_finish();
	end

	initial begin
		{reset, begin_request, sync_clear, reg_wr, reg_rd, sh_en} = 6'h20;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		target = 8'hA5;
		num_errors = 0;
		checked = 0;
		cyc(5);
		reset <= 1'b0;
		rd(`SAR_OFS_CTRL);
		`CHK(rv, 32'h0)
		rd(`SAR_OFS_MASK);
		`CHK(rv, 32'h0)
		rd(8'h10);
		`CHK(rv, 32'h0)
		rd(`SAR_OFS_RESULT);
		`CHK(rv, 32'h0)
		$display("reset values done");
		// strobed start, clear variant
		@(posedge ref_clk);
		begin_request <= 1'b1;
		cyc(3);
		begin_request <= 1'b0;
		wait_done(1'b1);
		`CHK(result_bits, 8'hA5)
		rd(`SAR_OFS_RESULT);
		`CHK(rv, 32'h1A5)
		cyc(20);
		@(negedge ref_clk);
		`CHK({conv_done, result_bits}, 9'h1A5)
		rd(`SAR_OFS_STATUS);
		`CHK(rv, 32'h3)
		`CHK(irq, 1'b0)
		wr(`SAR_OFS_MASK, 32'h1);
		@(negedge ref_clk);
		`CHK(irq, 1'b1)
		wr(`SAR_OFS_STATUS, 32'h1);
		@(negedge ref_clk);
		`CHK(irq, 1'b0)
		rd(`SAR_OFS_STATUS);
		`CHK(rv, 32'h2)
		$display("strobed conversion done");
		// clear, release with start low, then hold start high for one conversion
		@(posedge ref_clk);
		sync_clear <= 1'b1;
		cyc(8);
		@(negedge ref_clk);
		`CHK({conv_done, result_bits}, 9'h000)
		@(posedge ref_clk);
		sync_clear <= 1'b0;
		cyc(10);
		@(negedge ref_clk);
		`CHK({conv_done, result_bits}, 9'h000)
		target = 8'h3C;
		@(posedge ref_clk);
		begin_request <= 1'b1;
		wait_done(1'b1);
		`CHK(result_bits, 8'h3C)
		cyc(20);
		@(negedge ref_clk);
		`CHK({conv_done, result_bits}, 9'h13C)
		$display("clear and hold done");
		// feed-forward variant recirculates while start stays high
		target = 8'h5A;
		wr(`SAR_OFS_CTRL, 32'h1);
		wait_done(1'b0);
		wait_done(1'b1);
		`CHK(result_bits, 8'h5A)
		target = 8'hC3;
		wait_done(1'b0);
		wait_done(1'b1);
		`CHK(result_bits, 8'hC3)
		@(posedge ref_clk);
		begin_request <= 1'b0;
		cyc(20);
		@(negedge ref_clk);
		`CHK({conv_done, result_bits}, 9'h1C3)
		$display("recirculation done");
		// shortened conversion
		target = 8'hF0;
		sh_en <= 1'b1;
		@(posedge ref_clk);
		begin_request <= 1'b1;
		wait_done(1'b0);
		@(posedge ref_clk);
		begin_request <= 1'b0;
		wait_done(1'b1);
		`CHK(n, 0)
		`CHK(result_bits[7], 1'b1)
		$display("shortened conversion done");
		tally_and_finish();
	end
endmodule // sar_core_test

`default_nettype wire
